// >>> hw/dtc_pkg.sv
// package for the dual timer/event counter: register map, fields, modes
// assumes a 32-bit axi4-lite slave port with 6-bit register indices
package dtc_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_VALUE0 = 6'h0D;
  localparam logic [5:0] IDX_CTRL0 = 6'h0E;
  localparam logic [5:0] IDX_VALUE1 = 6'h10;
  localparam logic [5:0] IDX_CTRL1 = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;
  localparam logic [5:0] IDX_MASK = 6'h13;
  localparam logic [5:0] IDX_CONFIG = 6'h14;
  // control register fields
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_MODE_LSB = 6;
  // config register fields
  localparam int CFG_PFD_SRC_BIT = 0;
  localparam int CFG_PFD_LATCH_BIT = 1;
  localparam int CFG_PFD_OE_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [2:0] CFG_RST = 3'h0;
  // counting
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int PRESC_W = 7;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operating modes
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } dtc_mode_t;
  // pulse width measurement states, gray along arm-measure-done
  typedef enum logic [1:0] {
    PW_ARM = 2'h0,
    PW_MEAS = 2'h1,
    PW_DONE = 2'h3
  } dtc_pw_t;
endpackage

// >>> hw/dtc_top.sv
// dual 8-bit timer/event counter with axi4-lite registers, irq and divider out
// assumes event pins synchronous to aclk; one write and one read in flight
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module dtc_top (
  input wire logic aclk, // system clock, 10 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic counter0_value_or_pin, // event pin of counter 0
  input wire logic counter1_value_or_pin, // event pin of counter 1
  output logic shared_port_pin, // divider output level
  output logic shared_port_pin_oe, // divider output enable
  output logic irq, // level interrupt
  output logic wakeup // one-cycle wake-up pulse
);

  // maps a byte address onto a register index
  function automatic logic [5:0] reg_idx(input logic [7:0] addr);
    reg_idx = addr[7:2];
  endfunction

  // tells whether an index names a register
  function automatic logic is_mapped(input logic [5:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx == dtc_pkg::IDX_VALUE0) hit = 1'b1;
    else if (idx == dtc_pkg::IDX_CTRL0) hit = 1'b1;
    else if (idx == dtc_pkg::IDX_VALUE1) hit = 1'b1;
    else if (idx == dtc_pkg::IDX_CTRL1) hit = 1'b1;
    else if (idx == dtc_pkg::IDX_STATUS) hit = 1'b1;
    else if (idx == dtc_pkg::IDX_MASK) hit = 1'b1;
    else if (idx == dtc_pkg::IDX_CONFIG) hit = 1'b1;
    is_mapped = hit;
  endfunction

  // prescaler stage count to a mask of low prescaler bits
  function automatic logic [6:0] stage_mask(input logic [2:0] psc);
    logic [6:0] m;
    m = 7'h00;
    for (int k = 0; k < dtc_pkg::PRESC_W; k++) begin
      m[k] = (k < int'(psc));
    end
    stage_mask = m;
  endfunction

  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q, wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic do_write, rd_fire, wr_byte;
  logic [5:0] wr_idx, rd_idx;
  logic [1:0] wr_value, wr_ctrl, read_block, ovf, int_tick, count_en, run;
  logic [1:0][7:0] cnt_all, ctrl_all;
  logic [1:0] stat_q, mask_q;
  logic [2:0] cfg_q;
  logic [6:0] presc_q;
  logic pfd_q, pin_q, wakeup_q;
  logic rd_status;

  // write channel handshakes
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = reg_idx(awaddr_q);
  assign wr_byte = do_write && wstrb0_q;

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= dtc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(wr_idx) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // register write strobes per counter
  assign wr_value[0] = wr_byte && (wr_idx == dtc_pkg::IDX_VALUE0);
  assign wr_value[1] = wr_byte && (wr_idx == dtc_pkg::IDX_VALUE1);
  assign wr_ctrl[0] = wr_byte && (wr_idx == dtc_pkg::IDX_CTRL0);
  assign wr_ctrl[1] = wr_byte && (wr_idx == dtc_pkg::IDX_CTRL1);

  // read channel
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = reg_idx(s_axi_araddr);
  assign rd_status = rd_fire && (rd_idx == dtc_pkg::IDX_STATUS);
  assign read_block[0] = rd_fire && (rd_idx == dtc_pkg::IDX_VALUE0);
  assign read_block[1] = rd_fire && (rd_idx == dtc_pkg::IDX_VALUE1);

  // read data capture; live count returned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dtc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(rd_idx) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      if (rd_idx == dtc_pkg::IDX_VALUE0) rdata_q <= {24'h000000, cnt_all[0]};
      else if (rd_idx == dtc_pkg::IDX_CTRL0) rdata_q <= {24'h000000, ctrl_all[0]};
      else if (rd_idx == dtc_pkg::IDX_VALUE1) rdata_q <= {24'h000000, cnt_all[1]};
      else if (rd_idx == dtc_pkg::IDX_CTRL1) rdata_q <= {24'h000000, ctrl_all[1]};
      else if (rd_idx == dtc_pkg::IDX_STATUS) rdata_q <= {30'h0, stat_q};
      else if (rd_idx == dtc_pkg::IDX_MASK) rdata_q <= {30'h0, mask_q};
      else if (rd_idx == dtc_pkg::IDX_CONFIG) rdata_q <= {29'h0, cfg_q};
      else rdata_q <= 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // free-running prescaler shared by both internal sources
  always_ff @(posedge aclk) begin
    if (!aresetn) presc_q <= 7'h00;
    else presc_q <= presc_q + 7'h01;
  end

  assign int_tick[0] = (presc_q & stage_mask(ctrl_all[0][2:0])) == stage_mask(ctrl_all[0][2:0]);
  assign int_tick[1] = (presc_q[1:0] == dtc_pkg::DIV4_LAST);

  // one counter channel per generate iteration
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    logic [7:0] cnt_q, preload_q, ctrl_q;
    logic pin_now, pin_prev_q, ext_edge, start_lvl, pw_end;
    dtc_pkg::dtc_mode_t mode;
    dtc_pkg::dtc_pw_t pw_q;

    assign pin_now = (i == 0) ? counter0_value_or_pin : counter1_value_or_pin;
    assign mode = dtc_pkg::dtc_mode_t'(ctrl_q[dtc_pkg::CTRL_MODE_LSB +: 2]);
    assign run[i] = ctrl_q[dtc_pkg::CTRL_RUN_BIT];
    // edge select 0 rising, 1 falling
    assign ext_edge = ctrl_q[dtc_pkg::CTRL_EDGE_BIT] ? (pin_prev_q && !pin_now)
                                                      : (!pin_prev_q && pin_now);
    assign start_lvl = ctrl_q[dtc_pkg::CTRL_EDGE_BIT];
    // only a live pulse measurement may end and clear run
    assign pw_end = (pw_q == dtc_pkg::PW_MEAS) && (mode == dtc_pkg::MODE_PULSE)
                    && (pin_now == start_lvl);

    // pin history for edge detection
    always_ff @(posedge aclk) begin
      if (!aresetn) pin_prev_q <= 1'b0;
      else pin_prev_q <= pin_now;
    end

    always_comb begin
      count_en[i] = 1'b0;
      if (run[i] && !read_block[i]) begin
        case (mode)
          dtc_pkg::MODE_EVENT: count_en[i] = ext_edge;
          dtc_pkg::MODE_TIMER: count_en[i] = int_tick[i];
          dtc_pkg::MODE_PULSE: count_en[i] = (pw_q == dtc_pkg::PW_MEAS) && !pw_end
                                             && int_tick[i];
          default: count_en[i] = 1'b0;
        endcase
      end
    end

    assign ovf[i] = count_en[i] && (cnt_q == dtc_pkg::CNT_MAX);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pw_q <= dtc_pkg::PW_ARM;
      end else begin
        case (pw_q)
          dtc_pkg::PW_ARM: begin
            if (run[i] && mode == dtc_pkg::MODE_PULSE && ext_edge) pw_q <= dtc_pkg::PW_MEAS;
          end
          dtc_pkg::PW_MEAS: begin
            if (pw_end) pw_q <= dtc_pkg::PW_DONE;
            else if (!run[i] || mode != dtc_pkg::MODE_PULSE) pw_q <= dtc_pkg::PW_ARM;
          end
          dtc_pkg::PW_DONE: begin
            if (run[i]) pw_q <= dtc_pkg::PW_ARM;
          end
          default: pw_q <= dtc_pkg::PW_ARM;
        endcase
      end
    end

    // control register; software write wins over hardware run clear
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_q <= dtc_pkg::CTRL_RST;
      end else if (wr_ctrl[i]) begin
        ctrl_q <= wdata_q;
      end else if (pw_end) begin
        ctrl_q[dtc_pkg::CTRL_RUN_BIT] <= 1'b0;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) preload_q <= dtc_pkg::CNT_RST;
      else if (wr_value[i]) preload_q <= wdata_q;
    end

    // counter update
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q <= dtc_pkg::CNT_RST;
      end else if (wr_value[i] && !run[i]) begin
        cnt_q <= wdata_q;
      end else if (ovf[i]) begin
        cnt_q <= preload_q;
      end else if (count_en[i]) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end

    assign cnt_all[i] = cnt_q;
    assign ctrl_all[i] = ctrl_q;
  end

  // sticky flags, set beats read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) stat_q <= 2'h0;
    else stat_q <= ovf | (rd_status ? 2'h0 : stat_q);
  end

  // mask and config registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= dtc_pkg::MASK_RST;
      cfg_q <= dtc_pkg::CFG_RST;
    end else if (wr_byte) begin
      if (wr_idx == dtc_pkg::IDX_MASK) mask_q <= wdata_q[1:0];
      else if (wr_idx == dtc_pkg::IDX_CONFIG) cfg_q <= wdata_q[2:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) wakeup_q <= 1'b0;
    else wakeup_q <= |ovf;
  end

  assign wakeup = wakeup_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfd_q <= 1'b0;
      pin_q <= 1'b0;
    end else if (!cfg_q[dtc_pkg::CFG_PFD_LATCH_BIT]) begin
      pfd_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      if (ovf[cfg_q[dtc_pkg::CFG_PFD_SRC_BIT]]) pfd_q <= !pfd_q;
      pin_q <= pfd_q;
    end
  end

  assign shared_port_pin = pin_q;
  assign shared_port_pin_oe = cfg_q[dtc_pkg::CFG_PFD_OE_BIT];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ovf_reload;
    ovf[0] |=> cnt_all[0] == $past(g_cnt[0].preload_q);
  endproperty
  a_ovf_reload: assert property (p_ovf_reload) else $error("no reload on overflow");
  property p_flag_set;
    ovf[1] |=> stat_q[1] ##0 irq == mask_q[1] || irq;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_flag_sticky;
    stat_q[0] && !rd_status |=> stat_q[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
  property p_irq_mask;
    (mask_q == 2'h0) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
  property p_stop_load;
    wr_value[0] && !run[0] |=> cnt_all[0] == $past(wdata_q);
  endproperty
  a_stop_load: assert property (p_stop_load) else $error("stopped load failed");
  property p_run_hold;
    !run[0] && !wr_value[0] |=> $stable(cnt_all[0]);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("counted while stopped");
  property p_read_block;
    read_block[1] && !wr_value[1] |=> $stable(cnt_all[1]);
  endproperty
  a_read_block: assert property (p_read_block) else $error("counted during read");
  property p_pw_clear;
    g_cnt[0].pw_end && !wr_ctrl[0] |=> !run[0];
  endproperty
  a_pw_clear: assert property (p_pw_clear) else $error("run not cleared");
  property p_run_kept;
    run[1] && g_cnt[1].mode != dtc_pkg::MODE_PULSE && !wr_ctrl[1] |=> run[1];
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("run cleared by hw");
  property p_wake;
    (ovf != 2'h0) |=> wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake-up");
  property p_pfd_low;
    !cfg_q[dtc_pkg::CFG_PFD_LATCH_BIT] |=> !shared_port_pin;
  endproperty
  a_pfd_low: assert property (p_pfd_low) else $error("pin not held low");
  property p_div4;
    count_en[1] && g_cnt[1].mode == dtc_pkg::MODE_TIMER |-> presc_q[1:0] == 2'h3;
  endproperty
  a_div4: assert property (p_div4) else $error("counter 1 not at quarter rate");

  c_ovf0: cover property (ovf[0]);
  c_pw_done: cover property (g_cnt[1].pw_end);
  c_pfd_toggle: cover property (shared_port_pin ##1 !shared_port_pin);

endmodule // dtc_top

// >>> sim/dtc_pin_src.sv
// far-side model: a signal source that drives the two counter event pins
// assumes the pins are sampled on the rising edge of aclk, as the block expects
`timescale 1ns/1ps
module dtc_pin_src (
  input wire logic aclk, // system clock
  output logic pin0, // event pin of counter 0
  output logic pin1 // event pin of counter 1, follows pin 0
);
  // pins start low and stay driven, no pull needed
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
  end
  // one pulse on both pins: high for hi cycles, then low for lo cycles
  // a stopped counter ignores its pin, so the tests pick the listener
  task automatic pulse(input int hi, input int lo);
    @(posedge aclk);
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    repeat (hi) @(posedge aclk);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    repeat (lo) @(posedge aclk);
  endtask
endmodule // dtc_pin_src

// >>> sim/test_dtc_top.sv
// self-checking bench for the dual timer/event counter over axi4-lite
// assumes a 10 MHz aclk and the pin source model on the event pins
`timescale 1ns/1ps
module test_dtc_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin0, pin1, spin, spin_oe, irq, wakeup;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic spin_q = 1'b0;
  int n_errors = 0, n_compared = 0, n_wake = 0, n_tog = 0, cyc = 0;

  dtc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .counter0_value_or_pin(pin0), .counter1_value_or_pin(pin1), .shared_port_pin(spin),
    .shared_port_pin_oe(spin_oe), .irq(irq), .wakeup(wakeup));
  dtc_pin_src src_u (.aclk(aclk), .pin0(pin0), .pin1(pin1));

  // clock, 100 ns period
  initial begin
    forever #50 aclk = ~aclk;
  end
  // count cycles, wake-up pulses and divider pin toggles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    spin_q <= spin;
    if (wakeup === 1'b1) n_wake <= n_wake + 1;
    if (aresetn && spin !== spin_q) n_tog <= n_tog + 1;
  end

  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // axi write: address and data together, bready held until bvalid
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 50);
    r = bresp;
    bready <= 1'b0;
    if (t >= 50) chk(32'h0, 32'h1);
  endtask
  // axi read: rready held until rvalid
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (t >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk({30'h0, r}, {30'h0, dtc_pkg::RESP_OKAY});
    chk(d, exp);
  endtask

  // reset values and unmapped accesses
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdc(dtc_pkg::IDX_CTRL0, {24'h0, dtc_pkg::CTRL_RST});
    rdc(dtc_pkg::IDX_VALUE0, {24'h0, dtc_pkg::CNT_RST});
    rdc(dtc_pkg::IDX_MASK, 32'h0);
    rdc(dtc_pkg::IDX_CONFIG, 32'h0);
    chk({31'h0, spin_oe}, 32'h0);
    rd(6'h00, d, r);
    chk({30'h0, r}, {30'h0, dtc_pkg::RESP_SLVERR});
    wr(6'h00, 32'hFF, r);
    chk({30'h0, r}, {30'h0, dtc_pkg::RESP_SLVERR});
  endtask
  // timer mode of counter 0 through prescaler settings 0 to 3
  task automatic t_presc();
    logic [31:0] d;
    logic [1:0] r;
    int t0, e;
    for (int p = 0; p < 4; p++) begin
      wr(dtc_pkg::IDX_CTRL0, 32'h0, r);
      wr(dtc_pkg::IDX_VALUE0, 32'h0, r);
      t0 = cyc;
      wr(dtc_pkg::IDX_CTRL0, 32'h90 | p, r);
      repeat (30) @(posedge aclk);
      wr(dtc_pkg::IDX_VALUE0, 32'hF0, r);
      repeat (30) @(posedge aclk);
      wr(dtc_pkg::IDX_CTRL0, 32'h80 | p, r);
      e = cyc - t0;
      rd(dtc_pkg::IDX_VALUE0, d, r);
      chk(32'(d + 1 >= ((e - 8) >> p) && d <= (e >> p) + 1), 32'h1);
      repeat (10) @(posedge aclk);
      rdc(dtc_pkg::IDX_VALUE0, d);
    end
  endtask
  // event mode of counter 0, rising then falling edge, overflow masked
  task automatic t_event();
    logic [31:0] d;
    logic [1:0] r;
    int w;
    for (int e = 0; e < 2; e++) begin
      wr(dtc_pkg::IDX_CTRL0, 32'h0, r);
      wr(dtc_pkg::IDX_VALUE0, 32'hFE, r);
      wr(dtc_pkg::IDX_MASK, 32'h2, r);
      rd(dtc_pkg::IDX_STATUS, d, r);
      w = n_wake;
      wr(dtc_pkg::IDX_CTRL0, 32'h50 | (e << 3), r);
      repeat (3) src_u.pulse(2, 2);
      rdc(dtc_pkg::IDX_VALUE0, 32'hFF);
      chk({31'h0, irq}, 32'h0);
      rdc(dtc_pkg::IDX_STATUS, 32'h1);
      chk(32'(n_wake - w), 32'h1);
    end
  endtask
  // pulse width mode with overflow inside the measurement
  task automatic t_pulse();
    logic [31:0] d;
    logic [1:0] r;
    wr(dtc_pkg::IDX_CTRL0, 32'h0, r);
    wr(dtc_pkg::IDX_VALUE0, 32'hF8, r);
    rd(dtc_pkg::IDX_STATUS, d, r);
    wr(dtc_pkg::IDX_CTRL0, 32'hD0, r);
    src_u.pulse(12, 4);
    rd(dtc_pkg::IDX_VALUE0, d, r);
    chk(32'(d >= 32'hFA && d <= 32'hFE), 32'h1);
    rdc(dtc_pkg::IDX_CTRL0, 32'hC0);
    rdc(dtc_pkg::IDX_STATUS, 32'h1);
    src_u.pulse(6, 4);
    rdc(dtc_pkg::IDX_VALUE0, d);
  endtask
  // counter 1 timer drives divider and irq
  task automatic t_timer();
    logic [31:0] d;
    logic [1:0] r;
    int w, n0;
    wr(dtc_pkg::IDX_CONFIG, 32'h07, r);
    wr(dtc_pkg::IDX_MASK, 32'h2, r);
    rd(dtc_pkg::IDX_STATUS, d, r);
    // counter 1 counts falling pin edges
    wr(dtc_pkg::IDX_VALUE1, 32'hFD, r);
    wr(dtc_pkg::IDX_CTRL1, 32'h58, r);
    repeat (2) src_u.pulse(2, 2);
    rdc(dtc_pkg::IDX_VALUE1, 32'hFF);
    wr(dtc_pkg::IDX_CTRL1, 32'h0, r);
    wr(dtc_pkg::IDX_VALUE1, 32'hFC, r);
    w = n_wake;
    n0 = n_tog;
    wr(dtc_pkg::IDX_CTRL1, 32'h90, r);
    repeat (70) @(posedge aclk);
    chk(32'(n_wake - w >= 3 && n_wake - w <= 5), 32'h1);
    // running counter read stays between preload and top
    rd(dtc_pkg::IDX_VALUE1, d, r);
    chk(32'(d >= 32'hFC), 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(dtc_pkg::IDX_CTRL1, 32'h90);
    rdc(dtc_pkg::IDX_STATUS, 32'h2);
    chk(32'(n_tog - n0 >= 2), 32'h1);
    chk({31'h0, spin_oe}, 32'h1);
    wr(dtc_pkg::IDX_CONFIG, 32'h05, r);
    repeat (20) @(posedge aclk);
    chk({31'h0, spin}, 32'h0);
    wr(dtc_pkg::IDX_CTRL1, 32'h0, r);
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_presc();
    t_event();
    t_pulse();
    t_timer();
    test_done();
  end
  // watchdog, well beyond the several hundred cycles the tests need
  initial begin
    #(100 * 20000);
    n_errors++;
    test_done();
  end
endmodule // test_dtc_top
